//--- sos_top.sv
// Servo enable selection, rotation direction and overtravel gating.
// Overview of operation
// - Enable low energizes motor, servo on.
// - Enable high keeps motor de-energized.
// - Axis A enable defaults to terminal one.
// - Axis B enable defaults to terminal five.
// - Mapping value nine forces enable asserted.
// - Mapping changes apply only after reset.
// - Forced enable ignores alarm reset requests.
// - Standard direction: counterclockwise is forward.
// - Direction bit one reverses motor rotation.
// - Encoder output polarity ignores direction setting.
// - Positive limit ignores direction setting sense.
// - Positive limit high blocks positive motion.
// - Negative limit high blocks negative motion.
// - Overtravel stops motor, opposite motion allowed.
// - Overtravel keeps position error until cleared.
// - Clamp setting holds zero clamp while in overtravel.
`timescale 1ns/1ns
`include "sos_regs.svh"
module sos_top
(
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst_b,
   // Input terminals, active low; bit 0 is terminal one.
   input wire logic [`SOS_TERM_NUM-1:0] input_terminal,
   // Limit switch pins per axis, low means motion allowed.
   input wire logic [`SOS_AXES-1:0] fwd_limit_ok_b,
   input wire logic [`SOS_AXES-1:0] rev_limit_ok_b,
   // Controller pins: error clear per axis and alarm reset, active high.
   input wire logic [`SOS_AXES-1:0] position_error_clear,
   input wire logic alarm_reset_req,
   // Settings.
   input wire logic [`SOS_MAP_W-1:0] map_digit_a,
   input wire logic [`SOS_MAP_W-1:0] map_digit_b,
   input wire logic [`SOS_AXES-1:0] dir_reverse,
   input wire logic [`SOS_AXES-1:0] ot_zero_clamp_en,
   // Motion commands and alarm events from the control core.
   input wire logic [`SOS_AXES-1:0] cmd_step,
   input wire logic [`SOS_AXES-1:0] cmd_positive,
   input wire logic [`SOS_AXES-1:0] alarm_event,
   // Drive outputs.
   output logic [`SOS_AXES-1:0] servo_on,
   output logic [`SOS_AXES-1:0] motor_step,
   output logic [`SOS_AXES-1:0] motor_ccw,
   output logic [`SOS_AXES-1:0] overtravel_stop,
   output logic [`SOS_AXES-1:0] zero_clamp,
   output logic [`SOS_AXES-1:0] alarm_active,
   // Encoder pulse outputs.
   output logic [`SOS_AXES-1:0] encoder_out_a,
   output logic [`SOS_AXES-1:0] encoder_out_b,
   // Accumulated position error per axis.
   output logic [`SOS_AXES-1:0][`SOS_ERR_W-1:0] pos_error
);
   sos_pkg::sos_state_type state_r;
   sos_pkg::sos_state_type state_nxt;
   sos_pin_if pins ();

   assign pins.raw = {alarm_reset_req, position_error_clear,
      rev_limit_ok_b, fwd_limit_ok_b, input_terminal};

   sos_sync u_sync
   (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .pins(pins.syn)
   );

   // Resolve one axis enable from its latched mapping digit.
   function automatic logic enable_of
   (
      input logic [`SOS_MAP_W-1:0] map,
      input logic [`SOS_TERM_NUM-1:0] terms
   );
      logic [`SOS_MAP_W-1:0] idx;
      idx = map - `SOS_MAP_FIRST;
      enable_of = 1'b0;
      if (map == `SOS_MAP_ALWAYS)
      begin
         enable_of = 1'b1;
      end
      else if (map >= `SOS_MAP_FIRST && map <= `SOS_TERM_NUM)
      begin
         enable_of = !terms[idx[2:0]];
      end
   endfunction

   // Quadrature sequence; forward order makes phase A lead phase B.
   function automatic logic [1:0] quad_next
   (
      input logic [1:0] q,
      input logic fwd
   );
      logic [1:0] r;
      r = q;
      unique case ({fwd, q})
         3'h4: r = 2'h2;
         3'h6: r = 2'h3;
         3'h7: r = 2'h1;
         3'h5: r = 2'h0;
         3'h0: r = 2'h1;
         3'h1: r = 2'h3;
         3'h3: r = 2'h2;
         3'h2: r = 2'h0;
      endcase
      quad_next = r;
   endfunction

   always_comb
   begin
      logic [`SOS_TERM_NUM-1:0] terms;
      logic pos_ot;
      logic neg_ot;
      logic blocked;
      logic clr;
      logic arst;
      terms = pins.filt[`SOS_SB_TERM +: `SOS_TERM_NUM];
      pos_ot = 1'b0;
      neg_ot = 1'b0;
      blocked = 1'b0;
      clr = 1'b0;
      arst = pins.filt[`SOS_SB_ARST];
      state_nxt = state_r;
      if (!state_r.loaded)
      begin
         state_nxt.loaded = 1'b1;
         state_nxt.ax[0].map = map_digit_a;
         state_nxt.ax[1].map = map_digit_b;
      end
      for (int i = 0; i < `SOS_AXES; i++)
      begin
         pos_ot = pins.filt[`SOS_SB_FWD + i];
         neg_ot = pins.filt[`SOS_SB_REV + i];
         clr = pins.filt[`SOS_SB_CLR + i];
         state_nxt.ax[i].servo_on = state_r.loaded &&
            enable_of(state_r.ax[i].map, terms);
         blocked = cmd_positive[i] ? pos_ot : neg_ot;
         state_nxt.ax[i].ot_stop = state_r.ax[i].servo_on &&
            (pos_ot || neg_ot);
         state_nxt.ax[i].clamp = state_r.ax[i].servo_on &&
            (pos_ot || neg_ot) && ot_zero_clamp_en[i];
         state_nxt.ax[i].step = 1'b0;
         if (state_r.ax[i].servo_on && cmd_step[i] && !blocked)
         begin
            state_nxt.ax[i].step = 1'b1;
            state_nxt.ax[i].counterclockwise = cmd_positive[i] ^ dir_reverse[i];
            state_nxt.ax[i].quad = quad_next(state_r.ax[i].quad,
               cmd_positive[i]);
         end
         if (clr)
         begin
            state_nxt.ax[i].err = `SOS_ERR_RST;
         end
         else if (state_r.ax[i].servo_on && cmd_step[i] && blocked)
         begin
            state_nxt.ax[i].err = cmd_positive[i] ?
               state_r.ax[i].err + 16'h0001 :
               state_r.ax[i].err - 16'h0001;
         end
         if (alarm_event[i])
         begin
            state_nxt.ax[i].alarm = 1'b1;
         end
         else if (arst && state_r.ax[i].map != `SOS_MAP_ALWAYS)
         begin
            state_nxt.ax[i].alarm = 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_r <= '0;
         state_r.ax[0].map <= `SOS_MAP_A_RST;
         state_r.ax[1].map <= `SOS_MAP_B_RST;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   always_comb
   begin
      for (int i = 0; i < `SOS_AXES; i++)
      begin
         servo_on[i] = state_r.ax[i].servo_on;
         motor_step[i] = state_r.ax[i].step;
         motor_ccw[i] = state_r.ax[i].counterclockwise;
         overtravel_stop[i] = state_r.ax[i].ot_stop;
         zero_clamp[i] = state_r.ax[i].clamp;
         alarm_active[i] = state_r.ax[i].alarm;
         encoder_out_a[i] = state_r.ax[i].quad[1];
         encoder_out_b[i] = state_r.ax[i].quad[0];
         pos_error[i] = state_r.ax[i].err;
      end
   end
endmodule

//--- sos_regs.svh
// Constants for servo enable, direction and overtravel handling.
`ifndef SOS_REGS_SVH
`define SOS_REGS_SVH
`define SOS_AXES 2
`define SOS_TERM_NUM 8
`define SOS_MAP_W 4
`define SOS_MAP_ALWAYS 4'h9
`define SOS_MAP_FIRST 4'h1
`define SOS_MAP_A_RST 4'h1
`define SOS_MAP_B_RST 4'h5
`define SOS_ERR_W 16
`define SOS_SYNC_W 15
`define SOS_SB_TERM 0
`define SOS_SB_FWD 8
`define SOS_SB_REV 10
`define SOS_SB_CLR 12
`define SOS_SB_ARST 14
`define SOS_QUAD_RST 2'h0
`define SOS_SYNC_RST 15'h7fff
`define SOS_ERR_RST 16'h0000
`endif

//--- sos_pkg.sv
// Types shared by the servo enable and overtravel modules.
`include "sos_regs.svh"
package sos_pkg;
   typedef logic [`SOS_SYNC_W-1:0] sos_pins_type;
   typedef struct packed
   {
      sos_pins_type s1;
      sos_pins_type s2;
      sos_pins_type s3;
      sos_pins_type filt;
   } sos_sync_state_type;
   typedef struct packed
   {
      logic [`SOS_MAP_W-1:0] map;
      logic servo_on;
      logic step;
      logic counterclockwise;
      logic [1:0] quad;
      logic ot_stop;
      logic clamp;
      logic alarm;
      logic [`SOS_ERR_W-1:0] err;
   } sos_axis_type;
   typedef struct packed
   {
      logic loaded;
      sos_axis_type [`SOS_AXES-1:0] ax;
   } sos_state_type;
endpackage

//--- sos_pin_if.sv
// Carrier for raw pin levels and their synchronised, filtered copies.
`timescale 1ns/1ns
`include "sos_regs.svh"
interface sos_pin_if;
   sos_pkg::sos_pins_type raw;
   sos_pkg::sos_pins_type filt;
   modport src
   (
      output raw,
      input filt
   );
   modport syn
   (
      input raw,
      output filt
   );
endinterface

//--- sos_sync.sv
// Three-stage pin synchroniser with a two-stage agreement filter.
`timescale 1ns/1ns
`include "sos_regs.svh"
module sos_sync
(
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst_b,
   // Pins in, filtered levels out.
   sos_pin_if.syn pins
);
   sos_pkg::sos_sync_state_type state_r;
   sos_pkg::sos_sync_state_type state_nxt;

   // Only the second and third stages feed the filter, never the first.
   always_comb
   begin
      state_nxt = state_r;
      state_nxt.s1 = pins.raw;
      state_nxt.s2 = state_r.s1;
      state_nxt.s3 = state_r.s2;
      for (int i = 0; i < `SOS_SYNC_W; i++)
      begin
         if (state_r.s2[i] == state_r.s3[i])
         begin
            state_nxt.filt[i] = state_r.s3[i];
         end
      end
   end

   // Reset to the released level of every active-low pin.
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_r <= {4{`SOS_SYNC_RST & ~(15'h1 << `SOS_SB_ARST) &
            ~(15'h3 << `SOS_SB_CLR)}};
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   assign pins.filt = state_r.filt;
endmodule

//--- sos_chk.sv
// Checker of axis A step, encoder, overtravel and alarm behaviour.
`timescale 1ns/1ns
module sos_chk
(
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst_b,
   // Watched ports.
   input wire logic [1:0] cmd_step,
   input wire logic [1:0] cmd_positive,
   input wire logic [1:0] dir_reverse,
   input wire logic [1:0] alarm_event,
   input wire logic [1:0] position_error_clear,
   input wire logic [1:0] servo_on,
   input wire logic [1:0] motor_step,
   input wire logic [1:0] motor_ccw,
   input wire logic [1:0] overtravel_stop,
   input wire logic [1:0] zero_clamp,
   input wire logic [1:0] alarm_active,
   input wire logic [1:0] encoder_out_a,
   input wire logic [1:0] encoder_out_b,
   input wire logic [1:0][15:0] pos_error
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   a_step_runs: assert property (cmd_step[0] && servo_on[0]
      ##1 !overtravel_stop[0] |-> motor_step[0]) else $error("step lost");
   a_ccw_sense: assert property (motor_step[0] |-> motor_ccw[0] ==
      ($past(cmd_positive[0]) ^ $past(dir_reverse[0]))) else $error("dir");
   a_no_step_off: assert property (!servo_on[0] |=> !motor_step[0])
      else $error("step while off");
   a_quad_order: assert property (motor_step[0] |->
      {encoder_out_a[0], encoder_out_b[0]} == ($past(cmd_positive[0]) ?
      {~$past(encoder_out_b[0]), $past(encoder_out_a[0])} :
      {$past(encoder_out_b[0]), ~$past(encoder_out_a[0])}))
      else $error("quadrature order");
   a_enc_idle: assert property (!motor_step[0] |->
      $stable({encoder_out_a[0], encoder_out_b[0]})) else $error("enc");
   a_err_cause: assert property ($changed(pos_error[0]) |->
      $past(cmd_step[0]) || pos_error[0] == 16'h0000) else $error("err");
   a_clr_zero: assert property (position_error_clear[0] [*7] |->
      pos_error[0] == 16'h0000) else $error("clear ignored");
   a_clamp_ot: assert property (zero_clamp[0] |-> overtravel_stop[0])
      else $error("clamp without stop");
   a_alarm_set: assert property (alarm_event[0] |=> alarm_active[0])
      else $error("alarm not set");
   cover property (motor_step[0] && motor_ccw[0]);
   cover property (overtravel_stop[0] && zero_clamp[0]);
   cover property ($fell(alarm_active[0]));
endmodule
bind sos_top sos_chk chk_u (.*);

//--- sos_host.sv
// Host controller and limit switch model for both axes.
`timescale 1ns/1ns
module sos_host
(
   // Clock.
   input wire logic core_clk,
   // Requests from the bench.
   input wire logic [1:0] en_req,
   input wire logic [1:0] fwd_hit,
   input wire logic [1:0] rev_hit,
   input wire logic [1:0] go,
   input wire logic [1:0] pos,
   // Drive state seen back.
   input wire logic [1:0] servo_on,
   // Pins into the drive.
   output logic [7:0] terms = 8'hff,
   output logic [1:0] fwd_b = 2'h0,
   output logic [1:0] rev_b = 2'h0,
   output logic [1:0] step = 2'h0,
   output logic [1:0] dir = 2'h0
);
   // Unused terminals sit at their pull-up level; direction is only
   // meaningful with a step, so it toggles otherwise.
   always @(posedge core_clk)
   begin
      terms <= ~{3'h0, en_req[1], 3'h0, en_req[0]};
      fwd_b <= fwd_hit;
      rev_b <= rev_hit;
      step <= go & servo_on;
      dir <= (go & pos) | (~go & ~dir);
   end
endmodule

//--- test_sos_top.sv
// Self-checking bench for servo enable, direction and overtravel.
`timescale 1ns/1ns
module test_sos_top;
   logic core_clk = 0, rst_b = 0, arst = 0;
   logic [3:0] map_a = 4'h1, map_b = 4'h9;
   logic [1:0] en_req = 0, fwd_hit = 0, rev_hit = 0, go = 0, pos = 0;
   logic [1:0] rev = 0, clr = 0, alev = 0, clamp = 2'h3, quad = 0;
   logic [7:0] terms;
   logic [1:0] fwd_b, rev_b, step, dir, son, mst, counterclockwise, ots, zcl, alm, ea, eb;
   logic [1:0][15:0] perr;
   logic [15:0] exp_err = 0;
   logic [2:0] q[$];
   logic [2:0] e;
   int num_errors = 0, n_compared = 0, cyc = 0;
   always #2 core_clk = ~core_clk;
   sos_host host_u (.core_clk, .en_req, .fwd_hit, .rev_hit, .go, .pos,
      .servo_on(son), .terms, .fwd_b, .rev_b, .step, .dir);
   sos_top dut_u (.core_clk, .rst_b, .input_terminal(terms),
      .fwd_limit_ok_b(fwd_b), .rev_limit_ok_b(rev_b),
      .position_error_clear(clr), .alarm_reset_req(arst),
      .map_digit_a(map_a), .map_digit_b(map_b), .dir_reverse(rev),
      .ot_zero_clamp_en(clamp), .cmd_step(step), .cmd_positive(dir),
      .alarm_event(alev), .servo_on(son), .motor_step(mst), .motor_ccw(counterclockwise),
      .overtravel_stop(ots), .zero_clamp(zcl), .alarm_active(alm),
      .encoder_out_a(ea), .encoder_out_b(eb), .pos_error(perr));
   task automatic check(input string what, input logic [15:0] seen, exp);
      n_compared++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task wrap_up;
      $display("compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Back-to-back random steps on axis A; notes what each should do.
   task automatic steps(input int n);
      logic p;
      repeat (n)
      begin
         p = 1'($urandom % 2);
         go[0] <= 1'b1;
         pos[0] <= p;
         if (p ? !fwd_hit[0] : !rev_hit[0])
         begin
            quad = p ? {~quad[0], quad[1]} : {quad[0], ~quad[1]};
            q.push_back({p ^ rev[0], quad});
         end
         else
            exp_err = p ? exp_err + 16'h1 : exp_err - 16'h1;
         @(posedge core_clk);
      end
      go[0] <= 1'b0;
      wait_n(4);
      check("pending steps", 16'(q.size()), 16'h0);
   endtask
   always @(negedge core_clk)
      if (mst[0] === 1'b1)
      begin
         e = (q.size() > 0) ? q.pop_front() : 3'h0;
         check("step", {counterclockwise[0], ea[0], eb[0]}, e);
      end
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         num_errors++;
         wrap_up;
      end
   end
   initial
   begin
      void'($urandom(32'h97a4));
      wait_n(2);
      rst_b <= 1;
      wait_n(8);
      check("servo_on", son, 2'h2);
      alev <= 2'h3;
      wait_n(1);
      alev <= 0;
      arst <= 1;
      wait_n(8);
      check("alarm", alm, 2'h2);
      arst <= 0;
      en_req[0] <= 1;
      wait_n(8);
      check("servo_on", son[0], 1);
      steps(8);
      rev[0] <= 1;
      wait_n(1);
      steps(8);
      fwd_hit[0] <= 1;
      wait_n(8);
      check("clamp", {zcl[0], ots[0]}, 2'h3);
      clamp[0] <= 1'b0;
      wait_n(2);
      check("clamp off", {zcl[0], ots[0]}, 2'h1);
      clamp[0] <= 1'b1;
      steps(8);
      check("error", perr[0], exp_err);
      fwd_hit[0] <= 0;
      rev_hit[0] <= 1;
      wait_n(8);
      steps(8);
      check("error", perr[0], exp_err);
      clr[0] <= 1;
      wait_n(8);
      check("error", perr[0], 0);
      clr[0] <= 0;
      rev_hit[0] <= 0;
      map_a <= 4'h9;
      map_b <= 4'h5;
      en_req <= 2'h2;
      wait_n(8);
      check("servo_on", son[0], 0);
      rst_b <= 0;
      quad = 0;
      wait_n(2);
      rst_b <= 1;
      wait_n(8);
      check("servo_on", son, 2'h3);
      wrap_up;
   end
endmodule
